// File: abn_pkg.sv
// abn_pkg: register map, field positions and reset values of the encoder block
// assumes a 32-bit AXI4-Lite register bus, one aligned word per register
package abn_pkg;
	localparam logic [7:0] ADDR_MODE    = 8'h00;
	localparam logic [7:0] ADDR_POS     = 8'h04;
	localparam logic [7:0] ADDR_CONST   = 8'h08;
	localparam logic [7:0] ADDR_STATUS  = 8'h0c;
	localparam logic [7:0] ADDR_LATCH   = 8'h10;
	localparam logic [7:0] ADDR_IRQ     = 8'h14;
	localparam int BIT_POL_A       = 0;
	localparam int BIT_POL_B       = 1;
	localparam int BIT_POL_N       = 2;
	localparam int BIT_IGNORE_AB   = 3;
	localparam int BIT_CLR_CONT    = 4;
	localparam int BIT_CLR_ONCE    = 5;
	localparam int BIT_POS_EDGE    = 6;
	localparam int BIT_NEG_EDGE    = 7;
	localparam int BIT_CLR_ENC     = 8;
	localparam int BIT_LATCH_XACT  = 9;
	localparam int BIT_DECIMAL     = 10;
	localparam int BIT_INV_A       = 11;
	localparam int BIT_INV_B       = 12;
	localparam int MODE_BITS       = 13;
	localparam logic [12:0] MODE_RESET  = 13'h0000;
	localparam logic [31:0] CONST_RESET = 32'h0001_0000;
	localparam logic [31:0] POS_RESET   = 32'h0000_0000;
	localparam logic [31:0] LATCH_RESET = 32'h0000_0000;
	localparam logic [15:0] DEC_BASE   = 16'h2710;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: abn_encoder.sv
// abn_encoder: quadrature decoder with scaled position, index clear/latch
// assumes A/B/N already synchronous to clk_i and an AXI4-Lite master
//
// Summary of operation
// - continuous index mode clears or latches on every valid index event.
// - single-shot mode acts on next valid index, then disables itself.
// - index events optionally qualified by A and B levels.
// - both polarity flags set: index accepted only while A and B high.
// - clear position on index only when clear flag and a mode set.
// - each A or B edge adds or subtracts the scaling constant.
// - scaling constant is signed 16.16 fixed point.
// - binary mode negative constant is whole-word two's complement.
// - decimal mode low half holds ten-thousandths 0 to 9999.
// - negated constant reverses the counting direction.
// - accumulated position is readable at any time.
// - selectable active level for A, B and index inputs.
// - status event flag set when index clears or latches position.
// - each accepted index event copies position into latch register.
// - latch register is zero after reset, changed only by index.
// - reading the status flag clears it, even against a new event.
// - index-latch event shown on interrupt output.
`timescale 1ns/1ps
`default_nettype none
module abn_encoder
(
	input  wire logic        clk_i,          // 250 MHz clock
	input  wire logic        reset_i,        // sync reset, active high
	input  wire logic        enc_a_i,        // encoder channel A
	input  wire logic        enc_b_i,        // encoder channel B
	input  wire logic        enc_n_i,        // encoder index
	output logic             event_irq_o,    // index event pending
	input  wire logic [7:0]  s_axi_awaddr,   // write address
	input  wire logic        s_axi_awvalid,  // write address valid
	output logic             s_axi_awready,  // write address ready
	input  wire logic [31:0] s_axi_wdata,    // write data
	input  wire logic [3:0]  s_axi_wstrb,    // byte enables
	input  wire logic        s_axi_wvalid,   // write data valid
	output logic             s_axi_wready,   // write data ready
	output logic [1:0]       s_axi_bresp,    // write response
	output logic             s_axi_bvalid,   // write response valid
	input  wire logic        s_axi_bready,   // write response ready
	input  wire logic [7:0]  s_axi_araddr,   // read address
	input  wire logic        s_axi_arvalid,  // read address valid
	output logic             s_axi_arready,  // read address ready
	output logic [31:0]      s_axi_rdata,    // read data
	output logic [1:0]       s_axi_rresp,    // read response
	output logic             s_axi_rvalid,   // read data valid
	input  wire logic        s_axi_rready    // read data ready
);
	logic [12:0] mode;
	logic [31:0] enc_const;
	logic [31:0] enc_pos;
	logic [31:0] enc_latch;
	logic        ev_flag;
	logic        irq_en;
	logic        armed_once;
	logic [2:0]  pin_q;
	logic [2:0]  pin_d;
	logic        n_prev;
	logic [1:0]  ab_prev;
	logic [2:0]  warm;
	logic        a_l;
	logic        b_l;
	logic        n_l;
	logic        ab_edge;
	logic        dir_up;
	logic        n_edge;
	logic        qual_ok;
	logic        idx_event;
	logic [31:0] step;
	logic [31:0] next_pos;
	logic [15:0] frac_sum;
	logic [15:0] frac_dif;
	logic [15:0] int_add;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;
	logic        rd_take;
	logic        rd_status;

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = new_v[8*i +: 8];
		return r;
	endfunction

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pin_q <= 3'h0;
			pin_d <= 3'h0;
			n_prev <= 1'b0;
			ab_prev <= 2'h0;
			warm <= 3'h0;
		end
		else
		begin
			pin_q <= {enc_n_i, enc_b_i, enc_a_i};
			pin_d <= pin_q;
			n_prev <= n_l;
			ab_prev <= pin_d[1:0];
			// no edges until the pipeline holds real pin levels
			warm <= {warm[1:0], 1'b1};
		end
	end

	assign a_l = pin_d[0] ^ mode[abn_pkg::BIT_INV_A];
	assign b_l = pin_d[1] ^ mode[abn_pkg::BIT_INV_B];
	assign n_l = pin_d[2] ^ ~mode[abn_pkg::BIT_POL_N];

	assign ab_edge = warm[2] & (pin_d[1:0] != ab_prev);
	assign dir_up = a_l ^ (ab_prev[1] ^ mode[abn_pkg::BIT_INV_B]);

	assign qual_ok = mode[abn_pkg::BIT_IGNORE_AB]
		| ((a_l == mode[abn_pkg::BIT_POL_A])
		&& (b_l == mode[abn_pkg::BIT_POL_B]));
	assign n_edge = (mode[abn_pkg::BIT_POS_EDGE] & n_l & ~n_prev)
		| (mode[abn_pkg::BIT_NEG_EDGE] & ~n_l & n_prev)
		| (~mode[abn_pkg::BIT_POS_EDGE] & ~mode[abn_pkg::BIT_NEG_EDGE]
		& n_l & ~n_prev);
	assign idx_event = warm[2] & n_edge & qual_ok
		& (mode[abn_pkg::BIT_CLR_CONT] | armed_once);

	always_comb
	begin
		step = enc_const;
		int_add = enc_const[31:16];
		frac_sum = 16'h0000;
		frac_dif = 16'h0000;
		next_pos = enc_pos;
		if (mode[abn_pkg::BIT_DECIMAL])
		begin
			if (dir_up)
			begin
				frac_sum = enc_pos[15:0] + enc_const[15:0];
				if (frac_sum >= abn_pkg::DEC_BASE)
				begin
					frac_sum = frac_sum - abn_pkg::DEC_BASE;
					int_add = enc_const[31:16] + 16'h0001;
				end
				next_pos = {enc_pos[31:16] + int_add, frac_sum};
			end
			else
			begin
				frac_dif = enc_pos[15:0] - enc_const[15:0];
				if (enc_pos[15:0] < enc_const[15:0])
				begin
					frac_dif = frac_dif + abn_pkg::DEC_BASE;
					int_add = enc_const[31:16] + 16'h0001;
				end
				next_pos = {enc_pos[31:16] - int_add, frac_dif};
			end
		end
		else if (dir_up)
			next_pos = enc_pos + step;
		else
			next_pos = enc_pos - step;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			enc_pos <= abn_pkg::POS_RESET;
		else if (do_write && aw_addr == abn_pkg::ADDR_POS)
			enc_pos <= merge(enc_pos, w_data, w_strb);
		else if (idx_event && mode[abn_pkg::BIT_CLR_ENC])
			enc_pos <= abn_pkg::POS_RESET;
		else if (ab_edge)
			enc_pos <= next_pos;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			enc_latch <= abn_pkg::LATCH_RESET;
		else if (idx_event)
			enc_latch <= enc_pos;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			armed_once <= 1'b0;
		else if (do_write && aw_addr == abn_pkg::ADDR_MODE && w_strb[0])
			armed_once <= w_data[abn_pkg::BIT_CLR_ONCE];
		else if (idx_event)
			armed_once <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			ev_flag <= 1'b0;
		else if (rd_take && rd_status)
			ev_flag <= 1'b0;
		else if (idx_event)
			ev_flag <= 1'b1;
	end

	assign event_irq_o = ev_flag & irq_en;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			mode <= abn_pkg::MODE_RESET;
			enc_const <= abn_pkg::CONST_RESET;
			irq_en <= 1'b1;
		end
		else if (do_write)
		begin
			if (aw_addr == abn_pkg::ADDR_MODE)
				mode <= 13'(merge({19'h0, mode}, w_data, w_strb));
			if (aw_addr == abn_pkg::ADDR_CONST)
				enc_const <= merge(enc_const, w_data, w_strb);
			if (aw_addr == abn_pkg::ADDR_IRQ && w_strb[0])
				irq_en <= w_data[0];
		end
	end

	// axi write channel
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	assign do_write = aw_held & w_held & ~s_axi_bvalid;
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= abn_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == abn_pkg::ADDR_MODE
					|| aw_addr == abn_pkg::ADDR_POS
					|| aw_addr == abn_pkg::ADDR_CONST
					|| aw_addr == abn_pkg::ADDR_IRQ)
					? abn_pkg::RESP_OKAY : abn_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// axi read channel
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_take = s_axi_arvalid & s_axi_arready;
	assign rd_status = s_axi_araddr == abn_pkg::ADDR_STATUS;
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= abn_pkg::RESP_OKAY;
		end
		else if (rd_take)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= abn_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				abn_pkg::ADDR_MODE:
					s_axi_rdata <= {19'h0, mode[12:6], armed_once,
						mode[4:0]};
				abn_pkg::ADDR_POS:    s_axi_rdata <= enc_pos;
				abn_pkg::ADDR_CONST:  s_axi_rdata <= enc_const;
				abn_pkg::ADDR_STATUS: s_axi_rdata <= {31'h0, ev_flag};
				abn_pkg::ADDR_LATCH:  s_axi_rdata <= enc_latch;
				abn_pkg::ADDR_IRQ:    s_axi_rdata <= {31'h0, irq_en};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= abn_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule
`default_nettype wire

// File: abn_encoder_properties.sv
// abn_encoder_properties: bus timing and irq checks
// assumes binding onto abn_encoder ports
`timescale 1ns/1ps
`default_nettype none
module abn_encoder_properties
(
	input wire logic        clk_i,         // clock
	input wire logic        reset_i,       // reset
	input wire logic        event_irq_o,   // irq
	input wire logic        s_axi_awvalid, // aw
	input wire logic        s_axi_awready, // aw
	input wire logic        s_axi_wvalid,  // w
	input wire logic        s_axi_wready,  // w
	input wire logic        s_axi_bvalid,  // b
	input wire logic        s_axi_bready,  // b
	input wire logic [7:0]  s_axi_araddr,  // ar
	input wire logic        s_axi_arvalid, // ar
	input wire logic        s_axi_arready, // ar
	input wire logic [31:0] s_axi_rdata,   // r
	input wire logic [1:0]  s_axi_rresp,   // r
	input wire logic        s_axi_rvalid,  // r
	input wire logic        s_axi_rready   // r
);
	wire wr_take = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire unmapped = !(s_axi_araddr inside {abn_pkg::ADDR_MODE,
		abn_pkg::ADDR_POS, abn_pkg::ADDR_CONST, abn_pkg::ADDR_STATUS,
		abn_pkg::ADDR_LATCH, abn_pkg::ADDR_IRQ});
	wire st_read = ar_take & (s_axi_araddr == abn_pkg::ADDR_STATUS);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	a_write_answer: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer timing");
	a_read_answer: assert property (ar_take |=> s_axi_rvalid)
		else $error("read answer late");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_aw_blocked: assert property (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
		else $error("write taken while busy");
	a_unmapped_err: assert property (ar_take && unmapped |=>
		s_axi_rresp == abn_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read answer");
	a_mapped_okay: assert property (ar_take && !unmapped |=>
		s_axi_rresp == abn_pkg::RESP_OKAY)
		else $error("mapped read error");
	a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_irq_reset: assert property (disable iff (1'b0) reset_i |=> !event_irq_o)
		else $error("irq after reset");
	a_irq_read_clear: assert property (st_read |=> !event_irq_o)
		else $error("irq kept after status read");
	cover property (st_read && event_irq_o);
	cover property ($rose(event_irq_o));
	cover property (ar_take && unmapped);
	cover property (wr_take);
endmodule
bind abn_encoder abn_encoder_properties u_props (.*);
`default_nettype wire

// File: abn_quad_model.sv
// abn_quad_model: incremental encoder with quadrature and index
// assumes the bench calls its tasks right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module abn_quad_model
(
	input  wire logic clk_i,   // clock
	output logic      enc_a_o, // channel A
	output logic      enc_b_o, // channel B
	output logic      enc_n_o  // index
);
	initial
	begin
		enc_a_o = 1'b0;
		enc_b_o = 1'b0;
		enc_n_o = 1'b0;
	end
	// gray code steps, A leads B going up
	task automatic step(input logic up);
		@(posedge clk_i);
		if (enc_a_o ^ enc_b_o ^ up)
			enc_a_o <= ~enc_a_o;
		else
			enc_b_o <= ~enc_b_o;
		repeat (3) @(posedge clk_i);
	endtask
	// one index pulse, then settle time
	task automatic index();
		@(posedge clk_i);
		enc_n_o <= 1'b1;
		repeat (2) @(posedge clk_i);
		enc_n_o <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// File: abn_encoder_tb.sv
// abn_encoder_tb: register rows, stepping and index scenarios
// assumes abn_encoder, abn_pkg and the encoder model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module abn_encoder_tb;
	typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;} abn_row_t;
	logic        clk_i, reset_i, enc_a_i, enc_b_i, enc_n_i, event_irq_o;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	int          err_total, compares, cycles;
	abn_row_t    rows [8] = '{'{0, 8'h08, 32'h0001_0000}, '{0, 8'h04, 32'h0},
		'{0, 8'h10, 32'h0}, '{0, 8'h18, 32'h0},
		'{1, 8'h08, 32'h0019_1770}, '{0, 8'h08, 32'h0019_1770},
		'{1, 8'h10, 32'h0000_0055}, '{0, 8'h10, 32'h0}};
	abn_encoder uut (.*);
	abn_quad_model enc (.clk_i(clk_i), .enc_a_o(enc_a_i), .enc_b_o(enc_b_i),
		.enc_n_o(enc_n_i));
	task automatic end_sim();
		if (err_total == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw;
		logic [1:0] eb;
		ta = 1'b0;
		tw = 1'b0;
		eb = (a == abn_pkg::ADDR_MODE || a == abn_pkg::ADDR_POS
			|| a == abn_pkg::ADDR_CONST || a == abn_pkg::ADDR_IRQ)
			? abn_pkg::RESP_OKAY : abn_pkg::RESP_SLVERR;
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge clk_i);
			ta = ta | s_axi_awready;
			tw = tw | s_axi_wready;
			@(posedge clk_i);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		while (!(ta && tw));
		do @(negedge clk_i); while (!s_axi_bvalid);
		`CHK("bresp", eb, s_axi_bresp)
		@(posedge clk_i);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge clk_i); while (!s_axi_arready);
		@(posedge clk_i);
		s_axi_arvalid <= 1'b0;
		do @(negedge clk_i); while (!s_axi_rvalid);
		`CHK("reg", e, s_axi_rdata)
		@(posedge clk_i);
		s_axi_rready <= 1'b0;
	endtask
	task automatic steps(input int n, input logic up);
		repeat (n) enc.step(up);
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			end_sim();
		end
	end
	initial
	begin
		{reset_i, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h8;
		{s_axi_bready, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		`CHK("irq", 1'b0, event_irq_o)
		foreach (rows[i])
			if (rows[i].wr) wr(rows[i].a, rows[i].d);
			else rc(rows[i].a, rows[i].d);
		wr(8'h00, 32'h400);
		wr(8'h04, 32'h0);
		steps(2, 1'b1);
		rc(8'h04, 32'h0033_07d0);
		wr(8'h08, 32'hffe6_0fa0);
		steps(1, 1'b1);
		rc(8'h04, 32'h0019_1770);
		wr(8'h00, 32'h0);
		wr(8'h08, 32'h0001_0000);
		wr(8'h04, 32'h0);
		steps(3, 1'b1);
		steps(1, 1'b0);
		rc(8'h04, 32'h0002_0000);
		wr(8'h08, 32'hffff_0000);
		steps(2, 1'b1);
		rc(8'h04, 32'h0);
		wr(8'h00, 32'h12c);
		wr(8'h04, 32'h0005_0000);
		enc.index();
		`CHK("irq", 1'b1, event_irq_o)
		rc(8'h10, 32'h0005_0000);
		rc(8'h04, 32'h0);
		rc(8'h0c, 32'h1);
		`CHK("irq", 1'b0, event_irq_o)
		rc(8'h00, 32'h10c);
		wr(8'h04, 32'h7);
		enc.index();
		rc(8'h10, 32'h0005_0000);
		wr(8'h08, 32'h0);
		while (enc_a_i || enc_b_i) enc.step(1'b1);
		wr(8'h00, 32'h17);
		wr(8'h04, 32'h9);
		enc.index();
		`CHK("irq", 1'b0, event_irq_o)
		steps(2, 1'b1);
		enc.index();
		rc(8'h0c, 32'h1);
		enc.index();
		`CHK("irq", 1'b1, event_irq_o)
		rc(8'h10, 32'h9);
		wr(8'h14, 32'h0);
		`CHK("irq", 1'b0, event_irq_o)
		wr(8'h14, 32'h1);
		`CHK("irq", 1'b1, event_irq_o)
		wr(8'h00, 32'h800);
		wr(8'h08, 32'h0001_0000);
		wr(8'h04, 32'h0);
		steps(1, 1'b1);
		rc(8'h04, 32'hffff_0000);
		@(posedge clk_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		rc(8'h10, 32'h0);
		rc(8'h04, 32'h0);
		rc(8'h00, 32'h0);
		rc(8'h14, 32'h1);
		wr(8'h00, 32'h1800);
		steps(1, 1'b1);
		rc(8'h04, 32'h0001_0000);
		end_sim();
	end
endmodule
`default_nettype wire
